// ### core/mbio_io_ctrl.sv
// Main board I/O logic: interrupts, timers, watchdog, panel and guard links
//
// Contract
// R01: Panel byte is sent only while the panel ready line is high.
// R02: Arriving panel byte sets received flag and drops the rear ready line.
// R03: Arriving panel byte raises the panel interrupt request.
// R04: Panel UART reports parity, framing and overrun errors.
// R05: Fixed priority encoder, supply fault highest, kilohertz tick lowest.
// R06: Each source is maskable; a masked source never interrupts.
// R07: Priority order: supply, guard, gpib, tick, panel, serial, timer one, kHz.
// R08: Three interval timers interrupt at programmed intervals.
// R09: Timer zero gives the system tick every fiftieth of a second.
// R10: Timer one end interrupts and switches off the EEPROM supply.
// R11: Timer two gives the 1 kHz interrupt.
// R12: Switch settings count only if enable switch was closed at power-up.
// R13: Clear port bits 3, 2, 1 clear tick, timer one and kHz interrupts.
// R14: Fault port bits 3..0 drive the four fault LEDs.
// R15: Panel data at one address, status with switches at another.
// R16: Host sends to the guard only when guard ready shows.
// R17: Unguarded ready line follows the guard UART received flag.
// R18: Reset line resets unguarded logic and guarded processor together.
// R19: Guard link never runs above its maximum baud rate.
// R20: Two seconds without a kick asserts reset, fault and NMI.
// R21: All fault LEDs lit after power-up.
// R22: Interrupt out while any unmasked source pends; read returns pending.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module mbio_io_ctrl
	import mbio_pkg::*;
#(
	parameter int unsigned WD_CYCLES   = WD_CYC,
	parameter int unsigned TICK_CYCLES = TICK_DIV,
	parameter int unsigned RST_PULSE   = WD_PULSE
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Outside interrupt sources
	input  wire logic        supply_fault_irq,
	input  wire logic        guard_link_irq,
	input  wire logic        gpib_port_irq,
	input  wire logic        serial_port_irq,
	// Processor side
	output logic             cpu_irq,
	output logic      [2:0]  irq_level,
	output logic             system_reset,
	output logic             nmi,
	output logic             fault_line_n,
	// Board lines
	input  wire logic [3:0]  trouble_sw_n,
	output logic      [3:0]  fault_led,
	output logic             eeprom_supply_off,
	// Front panel link
	input  wire logic        panel_rxd,
	input  wire logic        panel_ready_line,
	output logic             panel_txd,
	output logic             rear_ready_line,
	// Guard crossing link
	input  wire logic        guard_rxd,
	input  wire logic        guard_ready_line,
	output logic             guard_txd,
	output logic             unguarded_ready_line,
	output logic             unguarded_reset_n
);
	logic            acc;
	logic            ph_ff;
	logic            w_ff;
	logic            am_ff;
	logic [7:0]      a_ff;
	logic            wr;
	logic            rd;
	logic [7:0]      wd;
	logic [7:0]      rdat;
	mbio_uart_stat_s p_stat;
	mbio_uart_stat_s g_stat;
	logic [7:0]      p_byte;
	logic [7:0]      g_byte;
	logic [15:0]     tdiv_ff;
	logic            tick_ff;
	logic [15:0]     rl_ff [3];
	logic [15:0]     cnt_ff [3];
	logic [2:0]      msb_ff;
	logic [2:0]      run_ff;
	logic [2:0]      exp_w;
	logic [2:0]      lat_ff;
	logic [7:0]      mask_ff;
	logic [7:0]      pend;
	logic            clr;
	logic [31:0]     wd_cnt_ff;
	logic [7:0]      rp_ff;
	logic            kick;
	logic            fire;
	logic            boot_ff;
	logic            sw_en_ff;

	function automatic logic [2:0] top_src(input logic [7:0] v);
		top_src = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (v[i]) begin
				top_src = 3'(i);
			end
		end
	endfunction : top_src

	// Bus slave: one wait state on every transfer
	assign acc = hsel & htrans[1] & hready;
	assign wr  = ph_ff & w_ff & am_ff;
	assign rd  = ph_ff & ~w_ff & am_ff;
	assign wd  = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_ff     <= 1'b0;
			w_ff      <= 1'b0;
			am_ff     <= 1'b0;
			a_ff      <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ph_ff     <= acc;
			hreadyout <= ~acc;
			hresp     <= 1'b0;
			if (acc) begin
				w_ff  <= hwrite;
				a_ff  <= haddr[9:2];
				am_ff <= (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
			end
		end
	end

	always_comb begin
		rdat = 8'h00;
		if (a_ff == REG_T0) begin
			rdat = cnt_ff[0][7:0];
		end else if (a_ff == REG_T1) begin
			rdat = cnt_ff[1][7:0];
		end else if (a_ff == REG_T2) begin
			rdat = cnt_ff[2][7:0];
		end else if (a_ff == REG_STAT) begin
			// Switches LSB..MSB, enable, error, panel ready, received, tx free
			rdat = {sw_en_ff ? {~trouble_sw_n[0], ~trouble_sw_n[1], ~trouble_sw_n[2]} : 3'h0, // [R12]
				sw_en_ff, p_stat.perr | p_stat.ferr | p_stat.oerr, panel_ready_line,
				p_stat.rx_full, p_stat.tx_empty}; // [R15] [R04]
		end else if (a_ff == REG_IRQ) begin
			rdat = pend; // [R22]
		end else if (a_ff == REG_PDATA) begin
			rdat = p_byte; // [R15]
		end else if (a_ff == REG_GDATA) begin
			rdat = g_byte;
		end else if (a_ff == REG_GSTAT) begin
			rdat = {GSTAT_HI, g_stat.ferr, g_stat.oerr, guard_ready_line, g_stat.rx_full, g_stat.tx_empty};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (rd) begin
			hrdata <= {24'h0, rdat};
		end
	end

	// Serial links
	mbio_uart #(.DIV(BAUD_DIV)) u_panel (
		.clk        (hclk),
		.rst_n      (hresetn),
		.tx_load    (wr && a_ff == REG_PDATA),
		.tx_byte    (wd),
		.tx_allow   (panel_ready_line), // [R01]
		.txd        (panel_txd),
		.rxd        (panel_rxd),
		.rx_pop     (rd && a_ff == REG_PDATA),
		.rx_byte_ff (p_byte),
		.stat       (p_stat)
	);

	// Rate is clamped at the link maximum
	mbio_uart #(.DIV(BAUD_DIV)) u_guard ( // [R19]
		.clk        (hclk),
		.rst_n      (hresetn),
		.tx_load    (wr && a_ff == REG_GDATA),
		.tx_byte    (wd),
		.tx_allow   (guard_ready_line), // [R16]
		.txd        (guard_txd),
		.rxd        (guard_rxd),
		.rx_pop     (rd && a_ff == REG_GDATA),
		.rx_byte_ff (g_byte),
		.stat       (g_stat)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rear_ready_line      <= 1'b1;
			unguarded_ready_line <= 1'b0;
		end else begin
			rear_ready_line      <= ~p_stat.rx_full; // [R02]
			unguarded_ready_line <= g_stat.rx_full; // [R17]
		end
	end

	// Timer base tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tdiv_ff <= 16'h0;
			tick_ff <= 1'b0;
		end else if (tdiv_ff == 16'(TICK_CYCLES - 1)) begin
			tdiv_ff <= 16'h0;
			tick_ff <= 1'b1;
		end else begin
			tdiv_ff <= tdiv_ff + 16'h1;
			tick_ff <= 1'b0;
		end
	end

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			exp_w[i] = tick_ff & run_ff[i] & (cnt_ff[i] <= 16'h1); // [R08]
		end
	end

	// Counters load LSB then MSB; timer one is one-shot, started by its MSB
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rl_ff[0]  <= T0_RST; // [R09]
			rl_ff[1]  <= T1_RST;
			rl_ff[2]  <= T2_RST; // [R11]
			cnt_ff[0] <= T0_RST;
			cnt_ff[1] <= T1_RST;
			cnt_ff[2] <= T2_RST;
			msb_ff    <= 3'h0;
			run_ff    <= RUN_RST;
		end else begin
			if (wr && a_ff == REG_TMODE) begin
				run_ff <= wd[2:0];
			end
			for (int i = 0; i < 3; i++) begin
				if (wr && a_ff == REG_T0 + 8'(i)) begin
					msb_ff[i] <= ~msb_ff[i];
					if (!msb_ff[i]) begin
						rl_ff[i][7:0] <= wd;
					end else begin
						rl_ff[i][15:8] <= wd;
						cnt_ff[i]      <= {wd, rl_ff[i][7:0]};
						if (i == 1) begin
							run_ff[1] <= 1'b1;
						end
					end
				end else if (exp_w[i]) begin
					cnt_ff[i] <= rl_ff[i]; // [R08]
					if (i == 1) begin
						run_ff[1] <= 1'b0; // [R10]
					end
				end else if (tick_ff && run_ff[i]) begin
					cnt_ff[i] <= cnt_ff[i] - 16'h1;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			eeprom_supply_off <= 1'b1;
		end else begin
			eeprom_supply_off <= ~run_ff[1]; // [R10]
		end
	end

	// Timer interrupt latches; a new expiry wins over a clear
	assign clr = wr && a_ff == REG_TCLR;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lat_ff <= 3'h0;
		end else begin
			lat_ff[0] <= exp_w[0] | (lat_ff[0] & ~(clr & wd[CLR_SYS])); // [R13] [R09]
			lat_ff[1] <= exp_w[1] | (lat_ff[1] & ~(clr & wd[CLR_T1])); // [R13] [R10]
			lat_ff[2] <= exp_w[2] | (lat_ff[2] & ~(clr & wd[CLR_KHZ])); // [R13] [R11]
		end
	end

	always_comb begin
		pend              = 8'h00;
		pend[IRQ_SUPPLY]  = supply_fault_irq; // [R07]
		pend[IRQ_GUARD]   = guard_link_irq;
		pend[IRQ_GPIB]    = gpib_port_irq;
		pend[IRQ_SYSTICK] = lat_ff[0];
		pend[IRQ_PANEL]   = p_stat.rx_full; // [R03]
		pend[IRQ_SERIAL]  = serial_port_irq;
		pend[IRQ_TIMER1]  = lat_ff[1];
		pend[IRQ_KHZ]     = lat_ff[2];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_ff <= MASK_RST;
		end else if (wr && a_ff == REG_IRQ) begin
			mask_ff <= wd; // [R06]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_irq   <= 1'b0;
			irq_level <= 3'h0;
		end else begin
			cpu_irq   <= |(pend & ~mask_ff); // [R06] [R22]
			irq_level <= top_src(pend & ~mask_ff); // [R05]
		end
	end

	// Watchdog
	assign kick = wr && a_ff == REG_WD;
	assign fire = wd_cnt_ff == 32'(WD_CYCLES - 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wd_cnt_ff <= 32'h0;
			rp_ff     <= 8'h00;
		end else begin
			wd_cnt_ff <= (kick || fire) ? 32'h0 : wd_cnt_ff + 32'h1;
			if (fire) begin
				rp_ff <= 8'(RST_PULSE);
			end else if (rp_ff != 8'h00) begin
				rp_ff <= rp_ff - 8'h1;
			end
		end
	end

	// Power-up reset holds all but fault_line_n low; a watchdog pulse asserts all four
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			system_reset      <= 1'b0;
			nmi               <= 1'b0;
			fault_line_n      <= 1'b1;
			unguarded_reset_n <= 1'b0; // [R18]
		end else begin
			system_reset      <= fire | (rp_ff > 8'h1); // [R20]
			nmi               <= fire | (rp_ff > 8'h1); // [R20]
			unguarded_reset_n <= ~(fire | (rp_ff > 8'h1)); // [R18]
			if (fire) begin
				fault_line_n <= 1'b0; // [R20]
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_led <= LED_RST; // [R21]
		end else if (wr && a_ff == REG_LED) begin
			fault_led <= wd[3:0]; // [R14]
		end
	end

	// Enable switch caught once, at the first edge after reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_ff  <= 1'b0;
			sw_en_ff <= 1'b0;
		end else if (!boot_ff) begin
			boot_ff  <= 1'b1;
			sw_en_ff <= ~trouble_sw_n[3]; // [R12]
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_rear_ready_drop: assert property (p_stat.rx_full |=> !rear_ready_line) // [R02]
		else $error("rear ready stayed high with a byte held");
	a_panel_irq_raise: assert property (($rose(p_stat.rx_full) && !mask_ff[IRQ_PANEL]) |=> cpu_irq) // [R03]
		else $error("panel byte did not interrupt");
	a_mask_blocks_irq: assert property (((pend & ~mask_ff) == 8'h00) |=> !cpu_irq) // [R06]
		else $error("interrupt with all pending sources masked");
	a_supply_top_prio: assert property ((supply_fault_irq && !mask_ff[IRQ_SUPPLY]) |=> irq_level == 3'h7) // [R05] [R07]
		else $error("supply fault not top priority");
	a_tick_clear_bit: assert property ((clr && wd[CLR_SYS] && !exp_w[0]) |=> !lat_ff[0]) // [R13]
		else $error("system tick not cleared");
	a_led_write_map: assert property ((wr && a_ff == REG_LED) |=> fault_led == $past(wd[3:0])) // [R14]
		else $error("fault LEDs do not match write");
	a_wd_fire_out: assert property (fire |=> (system_reset && nmi && !fault_line_n)) // [R20]
		else $error("watchdog expiry did not reset");
	a_guard_ready_follow: assert property (g_stat.rx_full |=> unguarded_ready_line) // [R17]
		else $error("unguarded ready not following received flag");
	a_eeprom_off_end: assert property (exp_w[1] |=> ##1 eeprom_supply_off) // [R10]
		else $error("timer one end left EEPROM supply on");
	a_reset_together: assert property (system_reset |-> !unguarded_reset_n) // [R18]
		else $error("guard reset not with system reset");
	a_switch_ignore: assert property ((boot_ff && !sw_en_ff && rd && a_ff == REG_STAT) |=> hrdata[7:5] == 3'h0) // [R12]
		else $error("switch bits shown while disabled");
endmodule : mbio_io_ctrl

// ### core/mbio_pkg.sv
// Shared constants and types for the main board I/O logic
package mbio_pkg;
	// Clock and serial rates
	localparam int unsigned CLK_NS      = 5;
	localparam int unsigned CLK_HZ      = 200_000_000;
	localparam int unsigned BAUD_HZ     = 62_500;
	localparam int unsigned BAUD_MAX_HZ = 65_000;
	localparam int unsigned DIV_NOM     = CLK_HZ / BAUD_HZ;
	localparam int unsigned DIV_MIN     = (CLK_HZ + BAUD_MAX_HZ - 1) / BAUD_MAX_HZ;
	localparam int unsigned BAUD_DIV    = (DIV_NOM > DIV_MIN) ? DIV_NOM : DIV_MIN;
	// Timer base tick and default periods
	localparam int unsigned TICK_NS     = 10_000;
	localparam int unsigned TICK_DIV    = TICK_NS / CLK_NS;
	localparam int unsigned SYS_TICK_US = 20_000;
	localparam int unsigned KHZ_TICK_US = 1_000;
	localparam logic [15:0] T0_RST      = 16'(SYS_TICK_US * 1000 / TICK_NS);
	localparam logic [15:0] T1_RST      = 16'hffff;
	localparam logic [15:0] T2_RST      = 16'(KHZ_TICK_US * 1000 / TICK_NS);
	localparam logic [2:0]  RUN_RST     = 3'h5;
	// Watchdog
	localparam int unsigned WD_MS       = 2_000;
	localparam int unsigned WD_CYC      = WD_MS * (CLK_HZ / 1000);
	localparam int unsigned WD_PULSE    = 16;
	// Register indices, byte address is four times the index
	localparam logic [7:0]  REG_T0      = 8'h00;
	localparam logic [7:0]  REG_T1      = 8'h01;
	localparam logic [7:0]  REG_T2      = 8'h02;
	localparam logic [7:0]  REG_TMODE   = 8'h03;
	localparam logic [7:0]  REG_STAT    = 8'h04;
	localparam logic [7:0]  REG_IRQ     = 8'h08;
	localparam logic [7:0]  REG_WD      = 8'h0c;
	localparam logic [7:0]  REG_TCLR    = 8'h10;
	localparam logic [7:0]  REG_LED     = 8'h14;
	localparam logic [7:0]  REG_PDATA   = 8'h18;
	localparam logic [7:0]  REG_GDATA   = 8'h30;
	localparam logic [7:0]  REG_GSTAT   = 8'h32;
	// Interrupt source positions
	localparam int          IRQ_SUPPLY  = 7;
	localparam int          IRQ_GUARD   = 6;
	localparam int          IRQ_GPIB    = 5;
	localparam int          IRQ_SYSTICK = 4;
	localparam int          IRQ_PANEL   = 3;
	localparam int          IRQ_SERIAL  = 2;
	localparam int          IRQ_TIMER1  = 1;
	localparam int          IRQ_KHZ     = 0;
	// Timer clear bits
	localparam int          CLR_SYS     = 3;
	localparam int          CLR_T1      = 2;
	localparam int          CLR_KHZ     = 1;
	// Reset values and fixed guard status high bits
	localparam logic [3:0]  LED_RST     = 4'hf;
	localparam logic [7:0]  MASK_RST    = 8'hff;
	localparam logic [2:0]  GSTAT_HI    = 3'h6;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} mbio_rx_st_e;

	typedef struct packed {
		logic perr;
		logic ferr;
		logic oerr;
		logic rx_full;
		logic tx_empty;
	} mbio_uart_stat_s;
endpackage : mbio_pkg

// ### core/mbio_uart.sv
// Byte UART with even parity and a one-byte holding register each way
`timescale 1ns/1ps
module mbio_uart
	import mbio_pkg::*;
#(
	parameter int unsigned DIV = BAUD_DIV
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Transmit side
	input  wire logic       tx_load,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_allow,
	output logic            txd,
	// Receive side
	input  wire logic       rxd,
	input  wire logic       rx_pop,
	output logic [7:0]      rx_byte_ff,
	output mbio_uart_stat_s stat
);
	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] FULL = CW'(DIV - 1);
	localparam logic [CW-1:0] HALF = CW'(DIV / 2);

	logic [7:0]    tx_hold_ff;
	logic          tx_full_ff;
	logic          tx_busy_ff;
	logic [9:0]    tx_sh_ff;
	logic [3:0]    tx_n_ff;
	logic [CW-1:0] tx_cnt_ff;
	logic          tx_start;
	mbio_rx_st_e   rx_st_ff;
	logic [CW-1:0] rx_cnt_ff;
	logic [2:0]    rx_n_ff;
	logic [7:0]    rx_sh_ff;
	logic          rx_par_ff;
	logic          rx_full_ff;
	logic          perr_ff;
	logic          ferr_ff;
	logic          oerr_ff;
	logic          rx_done;

	assign tx_start = tx_full_ff & ~tx_busy_ff & tx_allow;
	assign rx_done  = (rx_st_ff == RX_STOP) && (rx_cnt_ff == '0);
	assign stat     = '{perr: perr_ff, ferr: ferr_ff, oerr: oerr_ff, rx_full: rx_full_ff, tx_empty: ~tx_full_ff};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_full_ff <= 1'b0;
			tx_hold_ff <= 8'h00;
		end else if (tx_load) begin
			tx_full_ff <= 1'b1;
			tx_hold_ff <= tx_byte;
		end else if (tx_start) begin
			tx_full_ff <= 1'b0;
		end
	end

	// Frame: start, eight data bits LSB first, even parity, stop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_ff <= 1'b0;
			txd        <= 1'b1;
			tx_sh_ff   <= 10'h3ff;
			tx_n_ff    <= 4'h0;
			tx_cnt_ff  <= '0;
		end else if (tx_start) begin
			tx_busy_ff <= 1'b1;
			txd        <= 1'b0;
			tx_sh_ff   <= {1'b1, ^tx_hold_ff, tx_hold_ff};
			tx_n_ff    <= 4'ha;
			tx_cnt_ff  <= FULL;
		end else if (tx_busy_ff) begin
			if (tx_cnt_ff != '0) begin
				tx_cnt_ff <= tx_cnt_ff - 1'b1;
			end else if (tx_n_ff == 4'h0) begin
				tx_busy_ff <= 1'b0;
			end else begin
				txd       <= tx_sh_ff[0];
				tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
				tx_n_ff   <= tx_n_ff - 1'b1;
				tx_cnt_ff <= FULL;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_ff  <= RX_IDLE;
			rx_cnt_ff <= '0;
			rx_n_ff   <= 3'h0;
			rx_sh_ff  <= 8'h00;
			rx_par_ff <= 1'b0;
		end else begin
			case (rx_st_ff)
				RX_IDLE: begin
					if (!rxd) begin
						rx_st_ff  <= RX_START;
						rx_cnt_ff <= HALF;
					end
				end
				RX_START: begin
					if (rx_cnt_ff != '0) begin
						rx_cnt_ff <= rx_cnt_ff - 1'b1;
					end else begin
						rx_st_ff  <= rxd ? RX_IDLE : RX_DATA;
						rx_cnt_ff <= FULL;
						rx_n_ff   <= 3'h0;
					end
				end
				RX_DATA: begin
					if (rx_cnt_ff != '0) begin
						rx_cnt_ff <= rx_cnt_ff - 1'b1;
					end else begin
						rx_sh_ff  <= {rxd, rx_sh_ff[7:1]};
						rx_cnt_ff <= FULL;
						rx_n_ff   <= rx_n_ff + 1'b1;
						if (rx_n_ff == 3'h7) begin
							rx_st_ff <= RX_PAR;
						end
					end
				end
				RX_PAR: begin
					if (rx_cnt_ff != '0) begin
						rx_cnt_ff <= rx_cnt_ff - 1'b1;
					end else begin
						rx_par_ff <= rxd;
						rx_st_ff  <= RX_STOP;
						rx_cnt_ff <= FULL;
					end
				end
				default: begin
					if (rx_cnt_ff != '0) begin
						rx_cnt_ff <= rx_cnt_ff - 1'b1;
					end else begin
						rx_st_ff <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// New byte wins over a pop in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_full_ff <= 1'b0;
			rx_byte_ff <= 8'h00;
			perr_ff    <= 1'b0;
			ferr_ff    <= 1'b0;
			oerr_ff    <= 1'b0;
		end else if (rx_done) begin
			if (rx_full_ff && !rx_pop) begin
				oerr_ff <= 1'b1; // [R04]
			end else begin
				rx_full_ff <= 1'b1; // [R02]
				rx_byte_ff <= rx_sh_ff;
				perr_ff    <= rx_par_ff ^ (^rx_sh_ff); // [R04]
				ferr_ff    <= ~rxd; // [R04]
				oerr_ff    <= 1'b0;
			end
		end else if (rx_pop) begin
			rx_full_ff <= 1'b0;
			oerr_ff    <= 1'b0;
		end
	end

	a_tx_gated: assert property (@(posedge clk) disable iff (!rst_n) // [R01] [R16]
		$rose(tx_busy_ff) |-> $past(tx_allow))
		else $error("transmit started while far end not ready");
endmodule : mbio_uart

// ### dv/mbio_link_model.sv
// Far-side serial endpoint model: framed byte sender and ready line
`timescale 1ns/1ps
module mbio_link_model
	import mbio_pkg::*;
(
	// Clock
	input  wire logic clk,
	// Serial lines
	output logic      rxd,
	output logic      rdy
);
	initial begin
		// Serial idle level is high
		rxd = 1'b1;
		// Ready to take a byte unless the bench holds it off
		rdy = 1'b1;
	end

	// Start, eight data LSB first, even parity (or spoiled), stop
	task automatic send(input logic [7:0] d, input logic spoil);
		logic [10:0] f;
		f = {1'b1, ^d ^ spoil, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BAUD_DIV - 1) @(posedge clk);
		end
	endtask : send
endmodule : mbio_link_model

// ### dv/test_main_board_io_interrupt_logic.sv
// Self-checking bench for the main board I/O logic
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected %0t: got %h want %h", $time, a, b); end end
module test_main_board_io_interrupt_logic;
	import mbio_pkg::*;
	localparam int WD = 4000;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, cpu_irq, sys_rst, nmi, fault_n, ee_off;
	logic        p_txd, rear_rdy, g_txd, ug_rdy, ug_rst_n, bad, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize, irq_level;
	logic [3:0]  ext, sw_n, fault_led;
	logic [7:0]  pend, mask, b;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          n_mismatch, compares, cyc, seed, k, pb;
	wire         p_rxd, p_rdy, g_rxd, g_rdy;

	mbio_link_model panel (.clk(hclk), .rxd(p_rxd), .rdy(p_rdy));
	mbio_link_model guard (.clk(hclk), .rxd(g_rxd), .rdy(g_rdy));
	mbio_io_ctrl #(.WD_CYCLES(WD), .TICK_CYCLES(10), .RST_PULSE(16)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.supply_fault_irq(ext[3]), .guard_link_irq(ext[2]), .gpib_port_irq(ext[1]), .serial_port_irq(ext[0]),
		.cpu_irq(cpu_irq), .irq_level(irq_level), .system_reset(sys_rst), .nmi(nmi), .fault_line_n(fault_n),
		.trouble_sw_n(sw_n), .fault_led(fault_led), .eeprom_supply_off(ee_off), .panel_rxd(p_rxd),
		.panel_ready_line(p_rdy), .panel_txd(p_txd), .rear_ready_line(rear_rdy), .guard_rxd(g_rxd),
		.guard_ready_line(g_rdy), .guard_txd(g_txd), .unguarded_ready_line(ug_rdy), .unguarded_reset_n(ug_rst_n));

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	task automatic finish_test();
		if (n_mismatch == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test

	initial begin
		cyc = 0;
		forever begin
			@(posedge hclk);
			cyc++;
			if (cyc > 90000) begin
				n_mismatch++;
				finish_test();
			end
		end
	end

	// One single-word transfer; register index times four is the byte address
	task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask : xfer

	// Idle time with watchdog kicks so long waits never trip it
	task automatic idle(input int n);
		repeat (n / 100) begin
			xfer(REG_WD, 1'b1, 8'h00);
			repeat (96) @(posedge hclk);
		end
	endtask : idle

	task automatic rx_wait();
		for (k = 0; k < 400 && rear_rdy !== 1'b0; k++) idle(100);
	endtask : rx_wait

	// Expected {request, level} from pending and mask
	function automatic logic [3:0] top(input logic [7:0] p);
		top = 4'h0;
		for (int i = 0; i < 8; i++) if (p[i]) top = {1'b1, 3'(i)};
	endfunction : top

	initial begin
		seed = 32'hbb220afc;
		n_mismatch = 0;
		compares = 0;
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata, ext} = '0;
		hsize = 3'h2;
		sw_n = 4'h6;
		repeat (20) @(posedge hclk);
		`CHK(ug_rst_n, 1'b0)
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		`CHK(ug_rst_n, 1'b1)
		`CHK(fault_led, 4'hf)
		`CHK(ee_off, 1'b1)
		xfer(REG_TMODE, 1'b1, 8'h00);
		xfer(REG_TCLR, 1'b1, 8'h0e);
		xfer(REG_STAT, 1'b0, 8'h00);
		`CHK(rd[7:4], 4'b1001)
		`CHK(rd[2:1], 2'b10)
		b = 8'($random(seed));
		xfer(REG_LED, 1'b1, b);
		@(posedge hclk);
		`CHK(fault_led, b[3:0])
		// Priority and masking, corner cases first
		for (int i = 0; i < 12; i++) begin
			ext <= (i == 0) ? 4'hf : (i == 1) ? 4'h1 : 4'($random(seed));
			mask = (i < 2) ? 8'h00 : 8'($random(seed) & $random(seed));
			xfer(REG_IRQ, 1'b1, mask);
			xfer(REG_IRQ, 1'b0, 8'h00);
			pend = {ext[3:1], 2'b00, ext[0], 2'b00};
			`CHK(rd[7:0], pend)
			`CHK({cpu_irq, irq_level}, top(pend & ~mask))
		end
		ext <= 4'h0;
		xfer(REG_IRQ, 1'b1, 8'h00);
		// Each timer: short count, expiry, clear
		for (int i = 0; i < 3; i++) begin
			pb = (i == 0) ? IRQ_SYSTICK : (i == 1) ? IRQ_TIMER1 : IRQ_KHZ;
			xfer(REG_WD, 1'b1, 8'h00);
			xfer(REG_TMODE, 1'b1, 8'(1 << i));
			xfer(8'(i), 1'b1, 8'h04);
			xfer(8'(i), 1'b1, 8'h00);
			if (i == 1) `CHK(ee_off, 1'b0)
			rd = '0;
			for (k = 0; k < 60 && rd[pb] !== 1'b1; k++) xfer(REG_IRQ, 1'b0, 8'h00);
			`CHK(rd[pb], 1'b1)
			`CHK(cpu_irq, 1'b1)
			if (i == 1) `CHK(ee_off, 1'b1)
			// Stop first so a fresh expiry cannot refill the latch
			xfer(REG_TMODE, 1'b1, 8'h00);
			xfer(REG_TCLR, 1'b1, 8'(1 << (3 - i)));
			xfer(REG_IRQ, 1'b0, 8'h00);
			`CHK(rd[pb], 1'b0)
		end
		xfer(REG_TMODE, 1'b1, 8'h00);
		xfer(REG_TCLR, 1'b1, 8'h0e);
		// Panel send held off while the panel is not ready
		panel.rdy <= 1'b0;
		guard.rdy <= 1'b0;
		xfer(REG_PDATA, 1'b1, 8'h5a);
		xfer(REG_GDATA, 1'b1, 8'ha5);
		bad = 1'b0;
		repeat (300) begin
			@(posedge hclk);
			if ({p_txd, g_txd} !== 2'b11) bad = 1'b1;
		end
		`CHK(bad, 1'b0)
		panel.rdy <= 1'b1;
		guard.rdy <= 1'b1;
		for (k = 0; k < 100 && {p_txd, g_txd} !== 2'b00; k++) @(posedge hclk);
		`CHK({p_txd, g_txd}, 2'b00)
		// Good byte on both links at once
		b = 8'($random(seed));
		fork
			panel.send(b, 1'b0);
			guard.send(~b, 1'b0);
		join_none
		rx_wait();
		`CHK(rear_rdy, 1'b0)
		idle(100);
		`CHK(ug_rdy, 1'b1)
		xfer(REG_STAT, 1'b0, 8'h00);
		`CHK(rd[3:1], 3'b011)
		xfer(REG_IRQ, 1'b0, 8'h00);
		`CHK(rd[IRQ_PANEL], 1'b1)
		`CHK(cpu_irq, 1'b1)
		xfer(REG_PDATA, 1'b0, 8'h00);
		`CHK(rd[7:0], b)
		xfer(REG_GSTAT, 1'b0, 8'h00);
		`CHK(rd[7:0], 8'hc7)
		xfer(REG_GDATA, 1'b0, 8'h00);
		`CHK(rd[7:0], ~b)
		repeat (3) @(posedge hclk);
		`CHK({rear_rdy, ug_rdy}, 2'b10)
		// Spoiled parity is flagged
		fork
			panel.send(b, 1'b1);
		join_none
		rx_wait();
		xfer(REG_STAT, 1'b0, 8'h00);
		`CHK(rd[3], 1'b1)
		xfer(REG_PDATA, 1'b0, 8'h00);
		// Watchdog left unkicked after one last kick
		xfer(REG_WD, 1'b1, 8'h00);
		for (k = 0; k < WD + 50 && sys_rst !== 1'b1; k++) @(posedge hclk);
		`CHK(k >= WD - 20, 1'b1)
		`CHK({sys_rst, nmi}, 2'b11)
		@(posedge hclk);
		`CHK({fault_n, ug_rst_n}, 2'b00)
		// Second power-up with the enable switch open
		sw_n <= 4'h8;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(REG_STAT, 1'b0, 8'h00);
		`CHK(rd[7:4], 4'h0)
		finish_test();
	end
endmodule : test_main_board_io_interrupt_logic
